// file: pinmux_pkg.sv
package pinmux_pkg;
    localparam int NUM_LINES   = 8;   // I/O lines handled by the block
    localparam int NUM_FUNCS   = 4;   // Peripheral functions per line, listing order 0..3
    localparam int FSEL_W      = 2;   // Width of the winning function index
    localparam int TWI_FUNC    = 3;   // Function index that is the two-wire bus
    localparam int SPIKE_LEN   = 2;   // Stable samples needed by the two-wire spike filter
    localparam int TAP_TDI     = 0;   // Line carrying test data in
    localparam int TAP_TDO     = 1;   // Line carrying test data out
    localparam int TAP_TMS     = 2;   // Line carrying test mode select
    localparam int TAP_TCK     = 3;   // Line carrying test clock
    localparam logic [NUM_LINES-1:0] RST_PULLUP = 8'h00; // Pull-ups off after reset
    localparam logic [NUM_LINES-1:0] RST_OE_N   = 8'hff; // All lines inputs after reset
endpackage

// file: line_sel_if.sv
`timescale 1ns/100ps
interface line_sel_if;
    import pinmux_pkg::*;
    logic [NUM_FUNCS-1:0] enables; // Enabled functions on one line
    logic                 any_on;  // At least one function enabled
    logic [FSEL_W-1:0]    winner;  // Index of the function that owns the line
    modport req (output enables, input any_on, input winner);
    modport sel (input enables, output any_on, output winner);
endinterface

// file: line_prio_sel.sv
`timescale 1ns/100ps
module line_prio_sel
    import pinmux_pkg::*;
(
    line_sel_if.sel s  // Enable set in, winning index out
);
    // Scan in listing order so the last enabled function wins
    always_comb begin
        s.winner = '0;
        for (int f = 0; f < NUM_FUNCS; f++) begin
            if (s.enables[f]) begin
                s.winner = FSEL_W'(f);
            end
        end
    end

    assign s.any_on = |s.enables;
endmodule

// file: io_line_function_mux.sv
`timescale 1ns/100ps
module io_line_function_mux
    import pinmux_pkg::*;
#(
    parameter int LINES = NUM_LINES  // Number of I/O lines
)(
    input  wire logic                       mclk,            // System clock
    input  wire logic                       rst,             // Synchronous reset, high
    input  wire logic                       ext_reset_n,     // External reset pin level
    input  wire logic [LINES-1:0]           pad_in,          // Pad input levels
    output logic      [LINES-1:0]           pad_out,         // Pad output values
    output logic      [LINES-1:0]           pad_oe_n,        // Pad output enable, low drives
    output logic      [LINES-1:0]           pad_pullup,      // Pad pull-up enable
    input  wire logic [LINES-1:0]           port_out,        // Port logic output value
    input  wire logic [LINES-1:0]           port_oe,         // Port logic drive enable
    input  wire logic [LINES-1:0]           port_pullup,     // Port logic pull-up enable
    output logic      [LINES-1:0]           port_in,         // Sampled line to port logic
    input  wire logic [LINES*NUM_FUNCS-1:0] func_en,         // Per line function enables
    input  wire logic [LINES*NUM_FUNCS-1:0] func_out,        // Per line function outputs
    input  wire logic [LINES*NUM_FUNCS-1:0] func_oe,         // Per line function drive enables
    output logic      [LINES-1:0]           func_in,         // Line level to owning function
    input  wire logic                       tap_tdo,         // Test port data out
    input  wire logic                       tap_tdo_oe,      // Test port data out enable
    output logic                            tap_en,          // Test port enabled
    output logic                            tap_tck,         // Test clock to test port
    output logic                            tap_tms,         // Test mode select
    output logic                            tap_tdi,         // Test data in
    input  wire logic                       dbg_en,          // Single-pin debug enabled
    input  wire logic                       dbg_two_pin,     // Two-pin mode commanded
    input  wire logic                       dbg_data_out,    // Debug data drive value
    input  wire logic                       dbg_data_oe,     // Debug data drive enable
    output logic                            dbg_data_in,     // Debug data sampled
    output logic                            dbg_data_pin_o,  // Reset pin drive value
    output logic                            dbg_data_pin_oe_n, // Reset pin enable, low drives
    input  wire logic                       dbg_serial_bit,  // Debug serial output value
    output logic                            debug_serial_out, // Debug serial output pin
    output logic                            debug_serial_oe_n, // Its enable, low drives
    input  wire logic                       osc_sel,         // Unit routes oscillator pins
    input  wire logic                       osc_clk_in,      // Oscillator pin level
    output logic                            osc_clk_out      // Oscillator to control unit
);
    // Two-stage synchronisers for every pin-level input
    logic [LINES-1:0] pad_s1;
    logic [LINES-1:0] pad_s2;
    logic             rstn_s1;
    logic             rstn_s2;
    logic             rstn_d;
    logic             dbg_s1;
    logic             dbg_s2;
    logic             osc_s1;
    logic             osc_s2;

    always_ff @(posedge mclk) begin
        pad_s1  <= pad_in;
        pad_s2  <= pad_s1;
        rstn_s1 <= ext_reset_n;
        rstn_s2 <= rstn_s1;
        dbg_s1  <= ext_reset_n;
        dbg_s2  <= dbg_s1;
        osc_s1  <= osc_clk_in;
        osc_s2  <= osc_s1;
    end

    // Catch the test clock level at the rising edge of the external reset
    wire reset_release = rstn_s2 & ~rstn_d;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rstn_d <= rstn_s2; // Follow the pin so leaving reset with it high is no release
            tap_en <= 1'b0;
        end else begin
            rstn_d <= rstn_s2;
            if (reset_release) begin
                tap_en <= ~pad_s2[TAP_TCK];
            end
        end
    end

    // Per line priority selection and two-wire spike filter
    logic [LINES-1:0] next_out;
    logic [LINES-1:0] next_oe_n;
    logic [LINES-1:0] next_pu;
    logic [LINES-1:0] next_fin;
    logic [LINES-1:0] filt;

    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            line_sel_if           sif ();
            logic [SPIKE_LEN-1:0] hist;
            wire                  fsel;
            wire                  is_twi;
            wire                  f_o;
            wire                  f_oe;
            wire                  tap_pin;

            assign sif.enables = func_en[g*NUM_FUNCS +: NUM_FUNCS];
            line_prio_sel u_sel (
                .s (sif)
            );

            // Spike filter: input changes only after a stable run of samples
            always_ff @(posedge mclk) begin
                if (rst) begin
                    hist    <= '1;
                    filt[g] <= 1'b1;
                end else begin
                    hist <= {hist[SPIKE_LEN-2:0], pad_s2[g]};
                    if (&hist) begin
                        filt[g] <= 1'b1;
                    end else if (~|hist) begin
                        filt[g] <= 1'b0;
                    end
                end
            end

            assign fsel    = sif.any_on;
            assign is_twi  = fsel && (sif.winner == FSEL_W'(TWI_FUNC));
            assign f_o     = func_out[g*NUM_FUNCS + sif.winner];
            assign f_oe    = func_oe[g*NUM_FUNCS + sif.winner];
            assign tap_pin = tap_en && (g == TAP_TDI || g == TAP_TDO ||
                                        g == TAP_TMS || g == TAP_TCK);

            // Open-drain: two-wire only ever pulls low
            assign next_out[g]  = tap_pin ? tap_tdo :
                                  is_twi  ? 1'b0 :
                                  fsel    ? f_o : port_out[g];
            assign next_oe_n[g] = tap_pin ? ~((g == TAP_TDO) && tap_tdo_oe) :
                                  is_twi  ? ~(f_oe && !f_o) :
                                  fsel    ? ~f_oe : ~port_oe[g];
            assign next_pu[g]   = tap_pin ? (g != TAP_TDO) : port_pullup[g];
            assign next_fin[g]  = (tap_pin || !fsel) ? 1'b0 :
                                  is_twi ? filt[g] : pad_s2[g];
        end
    endgenerate

    // Registered pad side and peripheral side
    always_ff @(posedge mclk) begin
        if (rst) begin
            pad_out    <= '0;
            pad_oe_n   <= RST_OE_N;
            pad_pullup <= RST_PULLUP;
            port_in    <= '0;
            func_in    <= '0;
            tap_tck    <= 1'b0;
            tap_tms    <= 1'b0;
            tap_tdi    <= 1'b0;
        end else begin
            pad_out    <= next_out;
            pad_oe_n   <= next_oe_n;
            pad_pullup <= next_pu;
            port_in    <= pad_s2;
            func_in    <= next_fin;
            tap_tck    <= tap_en & pad_s2[TAP_TCK];
            tap_tms    <= tap_en & pad_s2[TAP_TMS];
            tap_tdi    <= tap_en & pad_s2[TAP_TDI];
        end
    end

    // Debug pins stay released until their interface is up; the reset pin
    // relies on the application not driving it while debug is active
    always_ff @(posedge mclk) begin
        if (rst) begin
            dbg_data_in       <= 1'b1;
            dbg_data_pin_o    <= 1'b0;
            dbg_data_pin_oe_n <= 1'b1;
            debug_serial_out  <= 1'b0;
            debug_serial_oe_n <= 1'b1;
            osc_clk_out       <= 1'b0;
        end else begin
            dbg_data_in       <= dbg_en ? dbg_s2 : 1'b1;
            dbg_data_pin_o    <= dbg_en & dbg_data_out;
            dbg_data_pin_oe_n <= ~(dbg_en & dbg_data_oe);
            debug_serial_out  <= dbg_en & dbg_two_pin & dbg_serial_bit;
            debug_serial_oe_n <= ~(dbg_en & dbg_two_pin);
            osc_clk_out       <= osc_sel & osc_s2;
        end
    end
endmodule

// file: io_line_function_mux_chk.sv
`timescale 1ns/100ps
module io_line_function_mux_chk
    import pinmux_pkg::*;
#(
    parameter int LINES = NUM_LINES  // Number of I/O lines
)(
    input wire logic mclk, rst, tap_en, tap_tdo_oe, dbg_en, dbg_two_pin, // Controls
    input wire logic dbg_data_pin_oe_n, debug_serial_oe_n,              // Debug enables
    input wire logic [LINES-1:0] pad_out, pad_oe_n, pad_pullup,         // Pad side
    input wire logic [LINES-1:0] port_out, port_oe, port_pullup,        // Port side
    input wire logic [LINES*NUM_FUNCS-1:0] func_en, func_out, func_oe   // Functions
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Line 5 carries the selection cases, lines 7..4 never belong to the test port
    property p_rst; disable iff (1'b0) rst |=> pad_oe_n == RST_OE_N && pad_pullup == RST_PULLUP; endproperty
    a_rst: assert property (p_rst) else $error("reset pad state wrong");
    property p_pull; !rst |=> pad_pullup[7:4] == $past(port_pullup[7:4]); endproperty
    a_pull: assert property (p_pull) else $error("pull-up not from port");
    property p_port; !rst && func_en[23:20] == 4'h0
        |=> pad_out[5] == $past(port_out[5]) && pad_oe_n[5] == !$past(port_oe[5]); endproperty
    a_port: assert property (p_port) else $error("port logic lost line");
    property p_prio; !rst && func_en[23:20] == 4'h5
        |=> pad_out[5] == $past(func_out[22]) && pad_oe_n[5] == !$past(func_oe[22]); endproperty
    a_prio: assert property (p_prio) else $error("wrong function owns line");
    property p_twi; !rst && func_en[23]
        |=> !pad_out[5] && pad_oe_n[5] == !($past(func_oe[23]) && !$past(func_out[23])); endproperty
    a_twi: assert property (p_twi) else $error("two-wire drive not open-drain");
    property p_tap; tap_en ##1 tap_en |-> pad_pullup[3:0] == 4'hd && pad_oe_n[1] == !$past(tap_tdo_oe); endproperty
    a_tap: assert property (p_tap) else $error("test port pins wrong");
    property p_dbg; !dbg_en |=> dbg_data_pin_oe_n; endproperty
    a_dbg: assert property (p_dbg) else $error("debug pin driven while off");
    property p_ser; !rst |=> debug_serial_oe_n == !$past(dbg_en && dbg_two_pin); endproperty
    a_ser: assert property (p_ser) else $error("serial out enable wrong");
endmodule
bind io_line_function_mux io_line_function_mux_chk #(.LINES(LINES)) chk (.*);

// file: board_model.sv
`timescale 1ns/100ps
module board_model
    import pinmux_pkg::*;
(
    input  wire logic mclk, dbg_en, rst_pin_n, dbg_data_pin_o, dbg_data_pin_oe_n, // Reset pin
    input  wire logic [NUM_LINES-1:0] pad_out, pad_oe_n, pad_pullup, ext_oe, ext_val, // Lines
    output logic [NUM_LINES-1:0] pad_in,  // Resolved line levels
    output logic ext_reset_n              // Resolved reset pin
);
    logic flip = 1'b0;  // Floating lines wander so a stale level never passes as a drive
    // Toggle source for undriven lines
    always @(posedge mclk) flip <= !flip;
    // Device drive wins, then board driver, then pull-up
    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_oe[i] ? ext_val[i] : pad_pullup[i] | flip;
        end
    end
    // Board lets go of reset pin while debug owns it; the pin has a pull-up
    assign ext_reset_n = !dbg_data_pin_oe_n ? dbg_data_pin_o : dbg_en ? 1'b1 : rst_pin_n;
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
    import pinmux_pkg::*;
    logic        mclk = 0, rst = 1, rst_pin_n = 0, ext_reset_n, tap_tdo = 0, tap_tdo_oe = 0;
    logic        tap_en, tap_tck, tap_tms, tap_tdi, dbg_en = 0, dbg_two_pin = 0, dbg_data_in;
    logic        dbg_data_out = 1, dbg_data_oe = 0, dbg_data_pin_o, dbg_data_pin_oe_n;
    logic        dbg_serial_bit = 0, debug_serial_out, debug_serial_oe_n;
    logic        osc_sel = 0, osc_clk_in = 1, osc_clk_out;
    logic [7:0]  pad_in, pad_out, pad_oe_n, pad_pullup, port_in, func_in;
    logic [7:0]  port_out = 0, port_oe = 0, port_pullup = 8'ha5, ext_oe = 8'h08, ext_val = 8'h08;
    logic [31:0] func_en = 0, func_out = 0, func_oe = 0;
    int          fail_count = 0, checked = 0, cycles = 0;
    // Line 5 rows: enables, outputs, drive enables, port out/oe, then expected out and oe_n
    logic [15:0] rows [7] = '{16'h000e, 16'h000b, 16'h1112, 16'h5442, 16'h7331, 16'h9991, 16'h8080};
    io_line_function_mux uut (.*);
    board_model pm (.*);
    initial begin forever #2 mclk = !mclk; end
    // Hang guard: the whole run needs well under a hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 500) begin
            fail_count++;
            results;
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence, inputs change on falling edges
    initial begin
        repeat (2) @(negedge mclk);
        chk("oe_n in reset", 8'hff, pad_oe_n);
        chk("pullup in reset", 8'h00, pad_pullup);
        rst = 0;
        @(negedge mclk);
        rst_pin_n = 1;
        repeat (10) @(negedge mclk);
        chk("tap off with clock high", 8'h00, {7'h0, tap_en});
        chk("pullups from port", 8'ha5, pad_pullup);
        foreach (rows[i]) begin
            {func_en[23:20], func_out[23:20], func_oe[23:20], port_out[5], port_oe[5]} = rows[i][15:2];
            @(negedge mclk);
            chk("line 5 out/oe_n", {6'h0, rows[i][1:0]}, {6'h0, pad_out[5], pad_oe_n[5]});
        end
        {func_en[0], func_out[0], func_oe[0]} = 3'h7;
        @(negedge mclk);
        chk("test pin as function", 8'h02, {6'h0, pad_out[0], pad_oe_n[0]});
        for (int i = 0; i < 4; i++) begin
            {dbg_en, dbg_two_pin} = i[1:0];
            {dbg_data_oe, dbg_serial_bit} = 2'h3;
            @(negedge mclk);
            chk("debug enables", {6'h0, i != 3, i < 2}, {6'h0, debug_serial_oe_n, dbg_data_pin_oe_n});
            chk("debug drives", {6'h0, i == 3, i > 1}, {6'h0, debug_serial_out, dbg_data_pin_o});
        end
        {dbg_en, dbg_two_pin, dbg_data_oe, osc_sel} = 4'h1;
        repeat (4) @(negedge mclk);
        chk("osc routed", 8'h01, {7'h0, osc_clk_out});
        osc_sel = 0;
        @(negedge mclk);
        chk("osc blocked", 8'h00, {7'h0, osc_clk_out});
        // Second reset with test clock held low at pin release
        {rst, rst_pin_n, ext_val[3]} = 3'h4;
        repeat (2) @(negedge mclk);
        rst = 0;
        repeat (2) @(negedge mclk);
        rst_pin_n = 1;
        repeat (8) @(negedge mclk);
        chk("tap on with clock low", 8'h01, {7'h0, tap_en});
        {func_en[7:4], func_oe[7:4], tap_tdo, tap_tdo_oe} = 10'h3f3;
        @(negedge mclk);
        chk("tap pull/oe_n", 8'hdd, {pad_pullup[3:0], pad_oe_n[3:0]});
        chk("tap data out", 8'h01, {7'h0, pad_out[1]});
        chk("tap inputs", 8'h03, {5'h0, tap_tck, tap_tms, tap_tdi});
        // Release the two-wire line to its pull-up, then pulse it low for one cycle
        func_oe[23:20] = 4'h0;
        repeat (8) @(negedge mclk);
        chk("released two-wire line", 8'h03, {6'h0, port_in[5], func_in[5]});
        {ext_oe[5], ext_val[5]} = 2'h2;
        @(negedge mclk);
        ext_oe[5] = 1'b0;
        repeat (6) begin
            @(negedge mclk);
            chk("spike filtered", 8'h01, {7'h0, func_in[5]});
        end
        results;
    end
endmodule
